// File: rtl/ocs_pkg.sv
// Purpose: Shared constants and carrier types for the output clock
//          start/stop and phase-step block.
// Assumes: AXI4-Lite register access, 32-bit data, 12-bit addresses.
// Notes:   Registers take one aligned word each, data in the low byte, the phase total in the low 16 bits.
package ocs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Word indices; the byte address is four times the index
  localparam logic [9:0] OFS_OUTPUT_CONFIG = 10'h200;
  localparam logic [9:0] OFS_OUTPUT_STATUS = 10'h204;
  localparam logic [9:0] OFS_START_STOP_CONTROL = 10'h208;
  localparam logic [9:0] OFS_PHASE_STEP = 10'h207;
  localparam logic [9:0] OFS_PHASE_TOTAL = 10'h210;

  localparam logic [7:0] RST_OUTPUT_CONFIG = 8'h00;
  localparam logic [7:0] RST_START_STOP_CONTROL = 8'h00;
  localparam logic [7:0] RST_PHASE_STEP = 8'h00;
  localparam logic [15:0] RST_PHASE_TOTAL = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Output configuration
  localparam int CFG_PHASE_EN = 0;
  localparam int CFG_FORMAT_LSB = 1;
  localparam int CFG_TRISTATE = 4;
  localparam int CFG_NEG_ROUTE = 5;
  localparam int CFG_INVERT = 6;
  localparam int CFG_SQUELCH = 7;
  // Start/stop control
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_SRC_LSB = 2;
  localparam int CTL_STOP = 7;
  // Status
  localparam int STS_LEVEL = 0;
  localparam int STS_REQ = 1;
  localparam int STS_HALTED = 2;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_NEVER = 2'h0;
  localparam logic [1:0] MODE_HIGH = 2'h1;
  localparam logic [1:0] MODE_LOW = 2'h2;

  localparam logic [3:0] SRC_SOFTWARE = 4'h0;
  localparam logic [3:0] SRC_PHASE_ARM = 4'h1;
  localparam logic [1:0] SRC_PIN_TAG = 2'h2;

  localparam logic [2:0] FMT_OFF = 3'h0;
  localparam logic [2:0] FMT_CML_STD = 3'h1;
  localparam logic [2:0] FMT_CML_NARROW = 3'h2;
  localparam logic [2:0] FMT_HSTL = 3'h3;
  localparam logic [2:0] FMT_CMOS_SAME = 3'h4;
  localparam logic [2:0] FMT_CMOS_NEG = 3'h5;
  localparam logic [2:0] FMT_CMOS_POS = 3'h6;
  localparam logic [2:0] FMT_CMOS_INV = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic rready;
  } ocs_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ocs_axi_rsp_type;

endpackage

// File: rtl/ocs_sync2.sv
// Purpose: Two-flop synchroniser for pin levels.
// Assumes: Inputs are slow levels, not pulses.
// Notes:   Only the second stage is visible to the rest of the block.
module ocs_sync2 #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= '0;
      synced <= '0;
    end else begin
      meta_reg <= async;
      synced <= meta_reg;
    end
  end

endmodule

// File: rtl/ocs_output_clock.sv
// Purpose: Start/stop gating, pin formatting and phase stepping for one
//          output clock, with an AXI4-Lite register slave.
// Assumes: fastClk and slowDivClk are levels from ref_clk logic;
//          gpioPin levels are asynchronous.
// Notes:   Pin outputs lag fastClk by two cycles.

// Summary of operation
// (RULE1) A phase step is applied only while phase shifting is enabled.
// (RULE2) Each phase adjustment event applies the step exactly once.
// (RULE3) The step is an 8-bit two's-complement count of half UI.
// (RULE4) Positive steps delay the edge, negative steps advance it.
// (RULE5) Source 0000 halts the output while the software stop bit is 1.
// (RULE6) Source 0001 halts on arming and restarts on adjust done.
// (RULE7) Sources 1000-1011 pick pins 0-3; other codes are not used.
// (RULE8) Mode 00 never halts; mode 11 is not used.
// (RULE9) Mode 01 halts high after a rise and resumes after a fall.
// (RULE10) Mode 10 halts low after a fall and resumes after a rise.
// (RULE11) The format chooses which pin shows the halted level.
// (RULE12) Halted with tristate set floats both pins above all else.
// (RULE13) Otherwise the slow-divider route drives the negative pin.
// (RULE14) Otherwise inversion swaps halt high and halt low.
// (RULE15) Auto-squelch halts the output while no reference is chosen.
// (RULE16) Halts and restarts occur only at clean clock edges.
module ocs_output_clock import ocs_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire ocs_axi_req_type axiReq,
  output ocs_axi_rsp_type axiRsp,
  // Clock sources
  input wire logic fastClk,
  input wire logic slowDivClk,
  // Phase adjustment and reference state
  input wire logic phaseAdjEvent,
  input wire logic phaseArmed,
  input wire logic adjustDoneLatched,
  input wire logic noRefSelected,
  // General-purpose pins
  input wire logic [3:0] gpioPin,
  // Output pins
  output logic outPositivePinO,
  output logic outPositivePinOe,
  output logic outNegativePinO,
  output logic outNegativePinOe,
  // Phase step to the output divider
  output logic phaseStepApply,
  output logic [7:0] phaseStepValue
);

  // ----------------------------------------------------------------
  // Registers and bus state
  // ----------------------------------------------------------------
  logic [7:0] cfgReg, ctlReg, stepReg;
  logic [15:0] totalReg;
  logic awHeldReg, wHeldReg, bvalidReg, rvalidReg, wStrbReg;
  logic [9:0] awIndexReg, arIndex;
  logic [7:0] wDataReg;
  logic [1:0] brespReg, rrespReg;
  logic [31:0] rdataReg;

  logic awTake, wTake, doWrite, arTake;
  logic wrMapped, rdMapped;
  logic [31:0] rdMux;

  assign awTake = axiReq.awvalid && !awHeldReg && !bvalidReg;
  assign wTake = axiReq.wvalid && !wHeldReg && !bvalidReg;
  assign doWrite = awHeldReg && wHeldReg && !bvalidReg;
  assign arTake = axiReq.arvalid && !rvalidReg;
  assign arIndex = axiReq.araddr[11:2];
  assign wrMapped = awIndexReg inside {OFS_OUTPUT_CONFIG,
                    OFS_START_STOP_CONTROL, OFS_PHASE_STEP};
  assign rdMapped = arIndex inside {OFS_OUTPUT_CONFIG, OFS_OUTPUT_STATUS,
                    OFS_START_STOP_CONTROL, OFS_PHASE_STEP, OFS_PHASE_TOTAL};

  assign axiRsp.awready = !awHeldReg && !bvalidReg;
  assign axiRsp.wready = !wHeldReg && !bvalidReg;
  assign axiRsp.bvalid = bvalidReg;
  assign axiRsp.bresp = brespReg;
  assign axiRsp.arready = !rvalidReg;
  assign axiRsp.rvalid = rvalidReg;
  assign axiRsp.rdata = rdataReg;
  assign axiRsp.rresp = rrespReg;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  logic phaseEn, tristate, negRoute, invert, autoSquelch, stopBit;
  logic [2:0] fmtSel;
  logic [1:0] modeSel;
  logic [3:0] srcSel;

  assign phaseEn = cfgReg[CFG_PHASE_EN];
  assign fmtSel = cfgReg[CFG_FORMAT_LSB +: 3];
  assign tristate = cfgReg[CFG_TRISTATE];
  assign negRoute = cfgReg[CFG_NEG_ROUTE];
  assign invert = cfgReg[CFG_INVERT];
  assign autoSquelch = cfgReg[CFG_SQUELCH];
  assign modeSel = ctlReg[CTL_MODE_LSB +: 2];
  assign srcSel = ctlReg[CTL_SRC_LSB +: 4];
  assign stopBit = ctlReg[CTL_STOP];

  // ----------------------------------------------------------------
  // Halt request selection
  // ----------------------------------------------------------------
  logic [3:0] gpioSync;
  logic armReqReg, srcReq, modeActive, haltReq, haltLevel;

  ocs_sync2 #(.WIDTH(4)) gpioSyncInst (
    .ref_clk(ref_clk),
    .rst(rst),
    .async(gpioPin),
    .synced(gpioSync)
  );

  assign srcReq = srcSel == SRC_SOFTWARE ? stopBit :         // see RULE5
                  srcSel == SRC_PHASE_ARM ? armReqReg :      // see RULE6
                  srcSel[3:2] == SRC_PIN_TAG ? gpioSync[srcSel[1:0]] :
                  1'b0;                                      // see RULE7
  // Mode 11 behaves as never-stop, the safe reading of a bad code
  assign modeActive = modeSel == MODE_HIGH || modeSel == MODE_LOW; // see RULE8
  assign haltReq = modeActive &&
                   (srcReq || (autoSquelch && noRefSelected)); // see RULE15
  assign haltLevel = modeSel == MODE_HIGH;                   // see RULE9, RULE10

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      armReqReg <= 1'b0;
    end else if (adjustDoneLatched) begin
      armReqReg <= 1'b0;                                     // see RULE6
    end else if (phaseArmed) begin
      armReqReg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Edge-aligned gating
  // ----------------------------------------------------------------
  logic prevClkReg, stoppedReg, holdReg, gatedReg;
  logic enterEdge, leaveEdge, stoppedNext, gatedNext;

  // Halt only on the edge into the halt level, resume only on the
  // edge out of it, so every phase seen on a pin is full length
  assign enterEdge = fastClk == haltLevel && prevClkReg != haltLevel;
  assign leaveEdge = fastClk != holdReg && prevClkReg == holdReg;
  assign stoppedNext = stoppedReg ? !(!haltReq && leaveEdge)
                                  : haltReq && enterEdge;   // see RULE16
  assign gatedNext = stoppedReg && stoppedNext ? holdReg : fastClk;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prevClkReg <= 1'b0;
      stoppedReg <= 1'b0;
      holdReg <= 1'b0;
      gatedReg <= 1'b0;
    end else begin
      prevClkReg <= fastClk;
      stoppedReg <= stoppedNext;                             // see RULE16
      if (!stoppedReg && stoppedNext) begin
        holdReg <= haltLevel;                                // see RULE9, RULE10
      end
      gatedReg <= gatedNext;
    end
  end

  // ----------------------------------------------------------------
  // Pin formatting
  // ----------------------------------------------------------------
  logic pathClk, posNext, posOeNext, negNext, negOeNext;
  logic fmtPos, fmtPosOe, fmtNeg, fmtNegOe, floatAll;

  // Inverting after the gate turns a high halt into a low one
  assign pathClk = gatedReg ^ invert;                        // see RULE14
  assign fmtPos = fmtSel == FMT_HSTL || fmtSel == FMT_CMOS_INV ?
                  !pathClk : pathClk;                        // see RULE11
  assign fmtNeg = fmtSel == FMT_CML_STD || fmtSel == FMT_CML_NARROW ?
                  !pathClk : pathClk;
  assign fmtPosOe = fmtSel != FMT_OFF && fmtSel != FMT_CMOS_NEG;
  assign fmtNegOe = fmtSel != FMT_OFF && fmtSel != FMT_CMOS_POS;
  assign floatAll = stoppedReg && tristate;                  // see RULE12
  assign posNext = floatAll ? 1'b0 : fmtPos;
  assign posOeNext = floatAll ? 1'b0 : fmtPosOe;
  assign negNext = floatAll ? 1'b0 :
                   negRoute ? slowDivClk : fmtNeg;           // see RULE13
  assign negOeNext = floatAll ? 1'b0 : negRoute || fmtNegOe;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      outPositivePinO <= 1'b0;
      outPositivePinOe <= 1'b0;
      outNegativePinO <= 1'b0;
      outNegativePinOe <= 1'b0;
    end else begin
      outPositivePinO <= posNext;
      outPositivePinOe <= posOeNext;
      outNegativePinO <= negNext;
      outNegativePinOe <= negOeNext;
    end
  end

  // ----------------------------------------------------------------
  // Phase stepping
  // ----------------------------------------------------------------
  logic eventPrevReg, eventRise;
  logic [15:0] stepExt;

  assign eventRise = phaseAdjEvent && !eventPrevReg;         // see RULE2
  // Half-UI units, sign extended: positive means a later edge
  assign stepExt = {{8{stepReg[7]}}, stepReg};               // see RULE3, RULE4

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eventPrevReg <= 1'b0;
      phaseStepApply <= 1'b0;
      phaseStepValue <= RST_PHASE_STEP;
      totalReg <= RST_PHASE_TOTAL;
    end else begin
      eventPrevReg <= phaseAdjEvent;
      phaseStepApply <= eventRise && phaseEn;                // see RULE1
      if (eventRise && phaseEn) begin
        phaseStepValue <= stepReg;
        totalReg <= totalReg + stepExt;                      // see RULE4
      end
    end
  end

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  assign rdMux = arIndex == OFS_OUTPUT_CONFIG ? {24'h00_0000, cfgReg} :
                 arIndex == OFS_START_STOP_CONTROL ? {24'h00_0000, ctlReg} :
                 arIndex == OFS_PHASE_STEP ? {24'h00_0000, stepReg} :
                 arIndex == OFS_PHASE_TOTAL ? {16'h0000, totalReg} :
                 arIndex == OFS_OUTPUT_STATUS ?
                   {29'h0000_0000, stoppedReg, haltReq, gatedReg} :
                 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeldReg <= 1'b0;
      wHeldReg <= 1'b0;
      awIndexReg <= 10'h000;
      wDataReg <= 8'h00;
      wStrbReg <= 1'b0;
    end else begin
      if (awTake) begin
        awHeldReg <= 1'b1;
        awIndexReg <= axiReq.awaddr[11:2];
      end
      if (wTake) begin
        wHeldReg <= 1'b1;
        wDataReg <= axiReq.wdata[7:0];
        wStrbReg <= axiReq.wstrb[0];
      end
      if (doWrite) begin
        awHeldReg <= 1'b0;
        wHeldReg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfgReg <= RST_OUTPUT_CONFIG;
      ctlReg <= RST_START_STOP_CONTROL;
      stepReg <= RST_PHASE_STEP;
      bvalidReg <= 1'b0;
      brespReg <= RESP_OKAY;
    end else begin
      if (doWrite) begin
        bvalidReg <= 1'b1;
        brespReg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        if (wStrbReg && awIndexReg == OFS_OUTPUT_CONFIG) cfgReg <= wDataReg;
        if (wStrbReg && awIndexReg == OFS_START_STOP_CONTROL) ctlReg <= wDataReg & 8'hBF;
        if (wStrbReg && awIndexReg == OFS_PHASE_STEP) stepReg <= wDataReg;
      end else if (bvalidReg && axiReq.bready) begin
        bvalidReg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rvalidReg <= 1'b0;
      rdataReg <= 32'h0000_0000;
      rrespReg <= RESP_OKAY;
    end else if (arTake) begin
      rvalidReg <= 1'b1;
      rdataReg <= rdMux;
      rrespReg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalidReg && axiReq.rready) begin
      rvalidReg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_phase_ignored: assert property ( // see RULE1
    !phaseEn |=> !phaseStepApply) else $error("step applied while disabled");
  a_step_once: assert property ( // see RULE2
    phaseStepApply |=> !phaseStepApply) else $error("step applied twice");
  a_step_total: assert property ( // see RULE3
    phaseStepApply |-> totalReg == $past(totalReg) + $past(stepExt))
    else $error("phase total wrong");
  a_never_halt: assert property ( // see RULE8
    !stoppedReg && modeSel == MODE_NEVER |=> !stoppedReg)
    else $error("halted in never-stop mode");
  a_halt_level: assert property ( // see RULE9
    $rose(stoppedReg) |-> gatedReg == ($past(modeSel) == MODE_HIGH))
    else $error("halted at wrong level");
  a_clean_edge: assert property ( // see RULE16
    stoppedReg != $past(stoppedReg) |->
      gatedReg == $past(fastClk) && $past(fastClk) != $past(prevClkReg))
    else $error("halt change off an edge");
  a_float_both: assert property ( // see RULE12
    stoppedReg && tristate |=> !outPositivePinOe && !outNegativePinOe)
    else $error("pins driven while floating");
  a_slow_route: assert property ( // see RULE13
    !(stoppedReg && tristate) && negRoute |=>
      outNegativePinOe && outNegativePinO == $past(slowDivClk))
    else $error("slow divider not on negative pin");
  a_invert_swap: assert property ( // see RULE14
    fmtSel == FMT_CMOS_SAME && !negRoute && !(stoppedReg && tristate) |=>
      outPositivePinO == ($past(gatedReg) ^ $past(invert)))
    else $error("inversion not applied");
  a_sw_source: assert property ( // see RULE5
    srcSel == SRC_SOFTWARE && modeActive && !autoSquelch |->
      haltReq == stopBit) else $error("software stop not followed");

  c_halt: cover property ($rose(stoppedReg));
  c_resume: cover property ($fell(stoppedReg));
  c_step: cover property (phaseStepApply);
  c_float: cover property (stoppedReg && tristate);

endmodule

// File: dv/output_clock_start_stop_phase_test.sv
// Purpose: Self-checking bench for the output clock start/stop block.
// Assumes: Pins lag fastClk by two cycles; bus answers per hand-over.
// Notes:   Bus and phase results go through one queue in issue order.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %0h got %0h", nm, e, g); end end

module output_clock_start_stop_phase_test
  import ocs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  ocs_axi_req_type req = '0;
  ocs_axi_rsp_type rsp;
  logic [1:0] fcCnt = 2'h0;
  wire fastClk = fcCnt[1];
  logic slowDivClk = 1'b0;
  logic phaseAdjEvent = 1'b0;
  logic phaseArmed = 1'b0;
  logic adjustDoneLatched = 1'b0;
  logic noRefSelected = 1'b0;
  logic [3:0] gpioPin = 4'h0;
  logic pO, pE, nO, nE, stepApply;
  logic [7:0] stepValue;
  logic [1:0] fh = 2'h0;
  logic [33:0] q[$];
  int fails = 0;
  int comparisons = 0;
  int seed = 32'h0000_0ca6;
  logic [2:0] curFmt = 3'h0;
  logic curInv = 1'b0;
  logic curTri = 1'b0;
  logic [15:0] total = 16'h0000;
  logic [31:0] v;

  always #5 ref_clk = ~ref_clk;

  // Fast clock of four cycles, and its history for the two-cycle lag
  always @(posedge ref_clk) begin
    fcCnt <= fcCnt + 2'h1;
    fh <= {fh[0], fastClk};
  end

  ocs_output_clock dut (
    .ref_clk(ref_clk), .rst(rst), .axiReq(req), .axiRsp(rsp),
    .fastClk(fastClk), .slowDivClk(slowDivClk),
    .phaseAdjEvent(phaseAdjEvent), .phaseArmed(phaseArmed),
    .adjustDoneLatched(adjustDoneLatched), .noRefSelected(noRefSelected),
    .gpioPin(gpioPin), .outPositivePinO(pO), .outPositivePinOe(pE),
    .outNegativePinO(nO), .outNegativePinOe(nE),
    .phaseStepApply(stepApply), .phaseStepValue(stepValue)
  );

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  task automatic take(input logic [33:0] got, input string nm);
    logic [33:0] e;
    if (q.size() == 0) begin
      fails++;
      $display("CHECK FAILED %s expected none got %0h", nm, got);
    end else begin
      e = q.pop_front();
      `CHK(nm, e, got)
    end
  endtask

  always @(posedge ref_clk) begin
    if (rsp.bvalid && req.bready) take({rsp.bresp, 32'h0000_0000}, "bresp");
    if (rsp.rvalid && req.rready) take({rsp.rresp, rsp.rdata}, "rdata");
    if (stepApply === 1'b1) take({26'h000_0000, stepValue}, "step");
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    q.push_back({r, 32'h0000_0000});
    @(posedge ref_clk);
    req.awaddr <= {a, 2'b00};
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!((rsp.awready || !req.awvalid) && (rsp.wready || !req.wvalid)));
    do @(posedge ref_clk); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    if (a == OFS_OUTPUT_CONFIG) begin
      curFmt = d[CFG_FORMAT_LSB +: 3];
      curInv = d[CFG_INVERT];
      curTri = d[CFG_TRISTATE];
    end
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    q.push_back({r, d});
    @(posedge ref_clk);
    req.araddr <= {a, 2'b00};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge ref_clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge ref_clk); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Pin checks
  // ----------------------------------------------------------------
  function automatic logic [3:0] expPins(input logic [2:0] f, input logic c);
    case (f)
      3'h1, 3'h2: expPins = {c, 1'b1, ~c, 1'b1};
      3'h3, 3'h7: expPins = {~c, 1'b1, c, 1'b1};
      3'h4: expPins = {c, 1'b1, c, 1'b1};
      3'h5: expPins = {2'b00, c, 1'b1};
      3'h6: expPins = {c, 1'b1, 2'b00};
      default: expPins = 4'h0;
    endcase
  endfunction

  task automatic chk(input logic [3:0] e);
    `CHK("pins", e, {pO & pE, pE, nO & nE, nE})
  endtask

  // Sampled at two fast clock phases, so a running clock cannot pass
  task automatic halted(input logic c);
    repeat (10) @(posedge ref_clk);
    chk(curTri ? 4'h0 : expPins(curFmt, c));
    repeat (2) @(posedge ref_clk);
    chk(curTri ? 4'h0 : expPins(curFmt, c));
  endtask

  task automatic run();
    repeat (8) @(posedge ref_clk);
    repeat (8) begin
      @(posedge ref_clk);
      chk(expPins(curFmt, fh[1] ^ curInv));
    end
  endtask

  task automatic event_pulse();
    @(posedge ref_clk);
    phaseAdjEvent <= 1'b1;
    repeat (3) @(posedge ref_clk);
    phaseAdjEvent <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Verdict and watchdog
  // ----------------------------------------------------------------
  task automatic conclude();
    if (q.size() != 0) fails++;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_START_STOP_CONTROL, 32'h0000_0000, RESP_OKAY);
    rd(OFS_PHASE_STEP, 32'h0000_0000, RESP_OKAY);
    rd(OFS_OUTPUT_CONFIG, 32'h0000_0000, RESP_OKAY);
    rd(10'h0C0, 32'h0000_0000, RESP_SLVERR);
    wr(10'h0C0, 32'h0000_00FF, RESP_SLVERR);
    v = $random(seed);
    v[4:3] = 2'b00;
    v[1] = v[1] & ~v[0];
    wr(OFS_START_STOP_CONTROL, {24'h00_0000, v[7:0]}, RESP_OKAY);
    rd(OFS_START_STOP_CONTROL, {24'h00_0000, v[7:0] & 8'hBF}, RESP_OKAY);
    wr(OFS_START_STOP_CONTROL, 32'h0000_0000, RESP_OKAY);
    // Step ignored while shifting is disabled
    wr(OFS_OUTPUT_CONFIG, 32'h0000_0002, RESP_OKAY);
    wr(OFS_PHASE_STEP, 32'h0000_0005, RESP_OKAY);
    event_pulse();
    wr(OFS_OUTPUT_CONFIG, 32'h0000_0003, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      if (i == 1) v[7:0] = 8'h7F;
      if (i == 2) v[7:0] = 8'h80;
      if (i == 3) v[7:0] = 8'hFF;
      wr(OFS_PHASE_STEP, {24'h00_0000, v[7:0]}, RESP_OKAY);
      q.push_back({26'h000_0000, v[7:0]});
      event_pulse();
      total = total + {{8{v[7]}}, v[7:0]};
    end
    rd(OFS_PHASE_TOTAL, {16'h0000, total}, RESP_OKAY);
    run();
    // Software stop in both modes over every format
    for (int m = 1; m < 3; m++) begin
      for (int f = 0; f < 8; f++) begin
        wr(OFS_OUTPUT_CONFIG, {28'h000_0000, f[2:0], 1'b0}, RESP_OKAY);
        wr(OFS_START_STOP_CONTROL, 32'h0000_0080 | m, RESP_OKAY);
        halted(m == 1);
        wr(OFS_START_STOP_CONTROL, m, RESP_OKAY);
        run();
      end
    end
    wr(OFS_START_STOP_CONTROL, 32'h0000_0080, RESP_OKAY);
    run();
    wr(OFS_START_STOP_CONTROL, 32'h0000_0084, RESP_OKAY);
    run();
    wr(OFS_OUTPUT_CONFIG, 32'h0000_0042, RESP_OKAY);
    run();
    wr(OFS_START_STOP_CONTROL, 32'h0000_0081, RESP_OKAY);
    halted(1'b0);
    wr(OFS_OUTPUT_CONFIG, 32'h0000_0012, RESP_OKAY);
    halted(1'b0);
    // Slow divider route on the negative pin
    for (int k = 0; k < 2; k++) begin
      v = $random(seed);
      slowDivClk <= v[0];
      wr(OFS_OUTPUT_CONFIG, 32'h0000_002C, RESP_OKAY);
      repeat (6) @(posedge ref_clk);
      `CHK("route", {v[0], 1'b1}, {nO, nE})
      wr(OFS_OUTPUT_CONFIG, 32'h0000_003C, RESP_OKAY);
      repeat (6) @(posedge ref_clk);
      `CHK("float", 4'h0, {pO, pE, nO, nE})
    end
    // Pin sources, a pin in never-stop mode, the arming source
    wr(OFS_OUTPUT_CONFIG, 32'h0000_0002, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_START_STOP_CONTROL, {24'h00_0000, 2'b00, 4'h8 + i[3:0], 2'b01},
         RESP_OKAY);
      gpioPin <= 4'h1 << i;
      halted(1'b1);
      gpioPin <= ~(4'h1 << i);
      run();
    end
    wr(OFS_START_STOP_CONTROL, 32'h0000_00AC, RESP_OKAY);
    gpioPin <= 4'hF;
    run();
    wr(OFS_START_STOP_CONTROL, 32'h0000_0005, RESP_OKAY);
    @(posedge ref_clk);
    phaseArmed <= 1'b1;
    @(posedge ref_clk);
    phaseArmed <= 1'b0;
    halted(1'b1);
    adjustDoneLatched <= 1'b1;
    @(posedge ref_clk);
    adjustDoneLatched <= 1'b0;
    run();
    // Auto-squelch only in the halting modes
    wr(OFS_OUTPUT_CONFIG, 32'h0000_0082, RESP_OKAY);
    wr(OFS_START_STOP_CONTROL, 32'h0000_0000, RESP_OKAY);
    noRefSelected <= 1'b1;
    run();
    wr(OFS_START_STOP_CONTROL, 32'h0000_0002, RESP_OKAY);
    halted(1'b0);
    noRefSelected <= 1'b0;
    run();
    conclude();
  end

endmodule
